// >>> common/spclk_pkg.sv
// package: register map, field positions and types for the serial port clock/polarity block
package spclk_pkg;
  // register byte addresses
  localparam logic [7:0] PIN_CONTROL_ADDR  = 8'h00;
  localparam logic [7:0] RATE_GEN_ADDR     = 8'h04;
  localparam logic [7:0] LOOP_CTRL_ADDR    = 8'h08;
  localparam logic [7:0] STATUS_ADDR       = 8'h0c;
  // pin_control field positions
  localparam int RX_CLOCK_POL_BIT  = 0;
  localparam int TX_CLOCK_POL_BIT  = 1;
  localparam int RX_FSYNC_POL_BIT  = 2;
  localparam int TX_FSYNC_POL_BIT  = 3;
  localparam int GEN_INPUT_MODE_BIT = 7;
  localparam int RX_CLOCK_MODE_BIT = 8;
  localparam int TX_CLOCK_MODE_BIT = 9;
  // writable bits of pin_control; reserved positions stay zero
  localparam logic [31:0] PIN_CONTROL_MASK = 32'h0000_038f;
  localparam logic [31:0] PIN_CONTROL_RESET = 32'h0000_0000;
  // rate generator register fields
  localparam int GEN_CLOCK_SELECT_BIT = 29;
  localparam int DIVIDER_WIDTH        = 8;
  localparam logic [31:0] RATE_GEN_MASK  = 32'h2000_00ff;
  // reset: internal clock, divider 1 so the generated clock runs at half rate
  localparam logic [31:0] RATE_GEN_RESET = 32'h2000_0001;
  // pin group on the link side
  typedef struct packed {
    logic rxClockPin;
    logic txClockPin;
    logic extClockSourcePin;
    logic rxFsyncPin;
    logic txFsyncPin;
  } link_in_t;
  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_INT = 2'b01,
    SRC_RX  = 2'b10,
    SRC_TX  = 2'b11
  } gen_src_t;
endpackage

// >>> verilog/serial_port_clock_polarity_select.sv
// serial port clock source, divider and pin polarity control behind an APB slave
//
// Behaviour
// - loopback on and rx clock mode 1: rx clock pin outputs transmit clock.
// - loopback off and rx clock mode 1: rx clock pin outputs generated clock.
// - generated clock frequency equals selected input divided by divider plus one.
// - after reset generator uses internal clock and runs at half rate.
// - input mode 0: select 0 takes external source pin, 1 internal clock.
// - input mode 1: select 0 takes rx clock pin, 1 tx clock pin.
// - reserved pin control bits read zero and writes to them do nothing.
// - bit 3 sets transmit frame-sync polarity, 1 meaning active low.
// - bit 2 sets receive frame-sync polarity, 1 meaning active low.
// - bit 1 chooses rising or falling transmit clock edge for transmit data.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module serial_port_clock_polarity_select #(
  parameter int DIV_W = 8
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire spclk_pkg::link_in_t   linkIn,
  input  wire logic                  rxData,
  output logic                       generatedClock,
  output logic                       txClockOut,
  output logic                       rxClockOut,
  output logic                       rxClockOe,
  output logic                       txFsyncActive,
  output logic                       rxFsyncActive,
  output logic                       txLaunch,
  output logic                       rxSampled
);
  logic [31:0]      pinControl;
  logic [31:0]      rateGen;
  logic             loopbackEnable;
  logic [DIV_W-1:0] divCount;
  logic             srcPrev;
  logic             txPrev;
  logic             rxPrev;
  // bus decode
  wire access   = psel & penable;
  wire wrPin    = access & pwrite & (paddr == spclk_pkg::PIN_CONTROL_ADDR);
  wire wrRate   = access & pwrite & (paddr == spclk_pkg::RATE_GEN_ADDR);
  wire wrLoop   = access & pwrite & (paddr == spclk_pkg::LOOP_CTRL_ADDR);
  wire mapped   = (paddr == spclk_pkg::PIN_CONTROL_ADDR) | (paddr == spclk_pkg::RATE_GEN_ADDR)
                | (paddr == spclk_pkg::LOOP_CTRL_ADDR) | (paddr == spclk_pkg::STATUS_ADDR);
  // control fields
  wire inputMode  = pinControl[spclk_pkg::GEN_INPUT_MODE_BIT];
  wire clockSel   = rateGen[spclk_pkg::GEN_CLOCK_SELECT_BIT];
  wire rxClkMode  = pinControl[spclk_pkg::RX_CLOCK_MODE_BIT];
  wire txClkMode  = pinControl[spclk_pkg::TX_CLOCK_MODE_BIT];
  wire [DIV_W-1:0] divider = rateGen[DIV_W-1:0];
  // polarity fields, named for the checks below
  wire txFsPol    = pinControl[spclk_pkg::TX_FSYNC_POL_BIT];
  wire rxFsPol    = pinControl[spclk_pkg::RX_FSYNC_POL_BIT];
  wire txClkPol   = pinControl[spclk_pkg::TX_CLOCK_POL_BIT];
  wire rxClkPol   = pinControl[spclk_pkg::RX_CLOCK_POL_BIT];
  // generator source select
  wire spclk_pkg::gen_src_t srcSel = spclk_pkg::gen_src_t'({inputMode, clockSel});
  wire srcLevel = (srcSel == spclk_pkg::SRC_EXT) ? linkIn.extClockSourcePin :
                  (srcSel == spclk_pkg::SRC_RX)  ? linkIn.rxClockPin :
                  (srcSel == spclk_pkg::SRC_TX)  ? linkIn.txClockPin : 1'b1;
  // one tick per input half period: internal input clock is clk/2, so it ticks every
  // cycle, and a pin source ticks on both of its edges; output period is divider+1 inputs
  wire srcTick  = (srcSel == spclk_pkg::SRC_INT) | (srcLevel ^ srcPrev);
  wire divWrap  = (divCount >= divider);
  // transmit clock: generator when driven internally, else the pin
  wire txClock  = txClkMode ? generatedClock : linkIn.txClockPin;
  wire next_rxClock = loopbackEnable ? txClock : generatedClock;
  // edge detection for data timing
  wire txRise = txClock & ~txPrev;
  wire txFall = ~txClock & txPrev;
  wire rxPin  = rxClockOe ? rxClockOut : linkIn.rxClockPin;
  wire rxRise = rxPin & ~rxPrev;
  wire rxFall = ~rxPin & rxPrev;
  wire rxEdge = pinControl[spclk_pkg::RX_CLOCK_POL_BIT] ? rxRise : rxFall;
  wire txEdge = pinControl[spclk_pkg::TX_CLOCK_POL_BIT] ? txFall : txRise;
  wire [31:0] status = {30'h0000_0000, generatedClock, rxClockOe};
  wire [31:0] readMux = (paddr == spclk_pkg::PIN_CONTROL_ADDR) ? pinControl :
                        (paddr == spclk_pkg::RATE_GEN_ADDR)    ? rateGen :
                        (paddr == spclk_pkg::LOOP_CTRL_ADDR)   ? {31'h0000_0000, loopbackEnable} :
                        (paddr == spclk_pkg::STATUS_ADDR)      ? status : 32'h0000_0000;
  // registers, reserved bits masked off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinControl     <= spclk_pkg::PIN_CONTROL_RESET;
      rateGen        <= spclk_pkg::RATE_GEN_RESET;
      loopbackEnable <= 1'b0;
    end else begin
      if (wrPin)
        pinControl <= pwdata & spclk_pkg::PIN_CONTROL_MASK;
      if (wrRate)
        rateGen <= pwdata & spclk_pkg::RATE_GEN_MASK;
      if (wrLoop)
        loopbackEnable <= pwdata[0];
    end
  end
  // apb answer: zero wait states
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= readMux;
      pslverr <= psel & ~penable & ~mapped;
    end
  end
  // divider: generated clock toggles every divider+1 source ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCount       <= '0;
      generatedClock <= 1'b0;
      srcPrev        <= 1'b0;
    end else begin
      srcPrev <= srcLevel;
      if (srcTick) begin
        if (divWrap) begin
          divCount       <= '0;
          generatedClock <= ~generatedClock;
        end else begin
          divCount <= divCount + 1'b1;
        end
      end
    end
  end
  // pin drive, polarity and data timing strobes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txClockOut    <= 1'b0;
      rxClockOut    <= 1'b0;
      rxClockOe     <= 1'b0;
      txFsyncActive <= 1'b0;
      rxFsyncActive <= 1'b0;
      txPrev        <= 1'b0;
      rxPrev        <= 1'b0;
      txLaunch      <= 1'b0;
      rxSampled     <= 1'b0;
    end else begin
      txClockOut    <= generatedClock;
      rxClockOut    <= next_rxClock;
      rxClockOe     <= rxClkMode;
      txFsyncActive <= linkIn.txFsyncPin ^ pinControl[spclk_pkg::TX_FSYNC_POL_BIT];
      rxFsyncActive <= linkIn.rxFsyncPin ^ pinControl[spclk_pkg::RX_FSYNC_POL_BIT];
      txPrev        <= txClock;
      rxPrev        <= rxPin;
      txLaunch      <= txEdge;
      if (rxEdge)
        rxSampled <= rxData;
    end
  end
  // checks
  property p_rx_loop;
    @(posedge clk) disable iff (rst)
      (rxClkMode && loopbackEnable) |=> (rxClockOe && rxClockOut == $past(txClock));
  endproperty
  a_rx_loop: assert property (p_rx_loop) else $error("rx clock not tx clock in loopback");
  property p_rx_gen;
    @(posedge clk) disable iff (rst)
      (rxClkMode && !loopbackEnable) |=> (rxClockOe && rxClockOut == $past(generatedClock));
  endproperty
  a_rx_gen: assert property (p_rx_gen) else $error("rx clock not generated clock");
  property p_div;
    @(posedge clk) disable iff (rst)
      (srcTick && !divWrap) |=> $stable(generatedClock);
  endproperty
  a_div: assert property (p_div) else $error("generated clock toggled early");
  property p_half;
    @(posedge clk) disable iff (rst)
      (srcSel == spclk_pkg::SRC_INT && divider == DIV_W'(1) && divCount == DIV_W'(1) && !wrRate)
        |=> (generatedClock != $past(generatedClock)) ##1 $stable(generatedClock);
  endproperty
  a_half: assert property (p_half) else $error("half rate divide wrong");
  property p_src_ext;
    @(posedge clk) disable iff (rst)
      (!inputMode && !clockSel) |-> (srcLevel == linkIn.extClockSourcePin);
  endproperty
  a_src_ext: assert property (p_src_ext) else $error("external source not selected");
  property p_src_pin;
    @(posedge clk) disable iff (rst)
      inputMode |-> (srcLevel == (clockSel ? linkIn.txClockPin : linkIn.rxClockPin));
  endproperty
  a_src_pin: assert property (p_src_pin) else $error("pin source wrong");
  property p_reserved;
    @(posedge clk) disable iff (rst)
      wrPin |=> ((pinControl & ~spclk_pkg::PIN_CONTROL_MASK) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");
  property p_tx_fs;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (txFsyncActive == ($past(linkIn.txFsyncPin) ^ $past(txFsPol)));
  endproperty
  a_tx_fs: assert property (p_tx_fs) else $error("tx frame sync polarity wrong");
  property p_rx_fs;
    @(posedge clk) disable iff (rst)
      1'b1 |=> (rxFsyncActive == ($past(linkIn.rxFsyncPin) ^ $past(rxFsPol)));
  endproperty
  a_rx_fs: assert property (p_rx_fs) else $error("rx frame sync polarity wrong");
  property p_tx_edge;
    @(posedge clk) disable iff (rst)
      (txRise && !txClkPol) |=> txLaunch;
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("tx edge missed");
  property p_rx_fall;
    @(posedge clk) disable iff (rst)
      (rxFall && !rxClkPol) |=> (rxSampled == $past(rxData));
  endproperty
  a_rx_fall: assert property (p_rx_fall) else $error("rx not sampled on fall");
  property p_rx_rise;
    @(posedge clk) disable iff (rst)
      (rxRise && rxClkPol) |=> (rxSampled == $past(rxData));
  endproperty
  a_rx_rise: assert property (p_rx_rise) else $error("rx not sampled on rise");
endmodule
`default_nettype wire

// >>> tb/serial_link_partner.sv
// far-side serial device model: pin clocks, frame syncs and receive data
`timescale 1ns/1ps
`default_nettype none
module serial_link_partner (
  input  wire logic           clk,
  input  wire logic           run,
  input  wire logic           sampleRise,
  input  wire logic [1:0]     fsyncLevel,
  output spclk_pkg::link_in_t linkIn,
  output logic                rxData
);
  logic [1:0] count = 2'h0;
  initial linkIn = 5'h00; // all pins idle low, as the edge detectors assume after reset
  initial rxData = 1'b0;
  // pin clocks move every 4 clk only while run is high; ext source at half rate
  always @(posedge clk) begin
    linkIn.rxFsyncPin <= fsyncLevel[0];
    linkIn.txFsyncPin <= fsyncLevel[1];
    count <= run ? count + 2'h1 : 2'h0;
    if (run && count == 2'h3) begin
      linkIn.rxClockPin <= ~linkIn.rxClockPin;
      linkIn.txClockPin <= ~linkIn.txClockPin;
      if (!linkIn.rxClockPin) linkIn.extClockSourcePin <= ~linkIn.extClockSourcePin;
      // data moves on the edge opposite to the sampling edge
      if (linkIn.rxClockPin == sampleRise) rxData <= ~rxData;
    end else if (!run) rxData <= ~rxData; // idle line toggles every clk
  end
endmodule
`default_nettype wire

// >>> tb/serial_port_clock_polarity_select_bench.sv
// self-checking bench: register access, generator rates, pin polarities
`timescale 1ns/1ps
`default_nettype none
module serial_port_clock_polarity_select_bench;
  localparam logic [7:0] PC = spclk_pkg::PIN_CONTROL_ADDR;
  localparam logic [7:0] RG = spclk_pkg::RATE_GEN_ADDR;
  localparam logic [7:0] LB = spclk_pkg::LOOP_CTRL_ADDR;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic run = 1'b0, sampleRise = 1'b0, probeSel = 1'b0, seen;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, wv;
  logic [1:0]  fsyncLevel = 2'h0;
  logic [3:0]  k;
  logic pready, pslverr, genClk, txClk, rxClk, rxOe, txAct, rxAct, txLaunch, rxSampled, rxData;
  spclk_pkg::link_in_t linkIn;
  logic [31:0] expQ[$];
  int fail_count = 0, check_count = 0, n;
  wire probe = probeSel ? rxClk : genClk;
  wire unmapped = paddr > spclk_pkg::STATUS_ADDR;
  logic genPrev = 1'b0;
  serial_port_clock_polarity_select i_serial_port_clock_polarity_select (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .linkIn(linkIn),
    .rxData(rxData), .generatedClock(genClk), .txClockOut(txClk), .rxClockOut(rxClk),
    .rxClockOe(rxOe), .txFsyncActive(txAct), .rxFsyncActive(rxAct), .txLaunch(txLaunch),
    .rxSampled(rxSampled));
  serial_link_partner i_serial_link_partner (.clk(clk), .run(run), .sampleRise(sampleRise),
    .fsyncLevel(fsyncLevel), .linkIn(linkIn), .rxData(rxData));
  initial forever #5 clk = ~clk;
  task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic complete_run;
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // clocks from one change of the probed clock to the next
  task automatic halfper(input int e);
    repeat (40) @(posedge clk);
    for (int j = 0; j < 2; j++) begin
      seen = probe; n = 0;
      while (probe === seen && n < 99) begin @(posedge clk); n++; end
    end
    check("halfPeriod", n, e);
  endtask
  task automatic edge_seen(input logic r);
    wait (linkIn.txClockPin !== r);
    wait (linkIn.txClockPin === r);
    seen = 1'b0;
    repeat (3) begin @(posedge clk); seen = seen | txLaunch; end
  endtask
  // read results are compared against the oldest note; unmapped offsets answer with an error
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) check("prdata", prdata, expQ.pop_front());
    if (psel && penable && pready) check("pslverr", pslverr, {31'h0, unmapped});
  end
  // tx clock output follows the generated clock one cycle late
  always @(posedge clk) begin
    if (!rst) check("txClockOut", txClk, {31'h0, genPrev});
    genPrev = genClk;
  end
  initial begin #300000; fail_count++; complete_run(); end
  initial begin
    void'($urandom(32'h9b04));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(PC, spclk_pkg::PIN_CONTROL_RESET);
    rd(RG, spclk_pkg::RATE_GEN_RESET);
    halfper(2);
    wv = $urandom & ~32'h40;
    apb(1'b1, PC, wv);
    rd(PC, wv & spclk_pkg::PIN_CONTROL_MASK);
    rd(8'h10, 32'h0);
    apb(1'b1, PC, 32'h0);
    apb(1'b1, RG, 32'h2000_0003);
    halfper(4);
    apb(1'b1, RG, 32'h0);
    halfper(99);
    run <= 1'b1;
    halfper(8);
    apb(1'b1, PC, 32'h80);
    halfper(4);
    apb(1'b1, RG, 32'h2000_0000);
    halfper(4);
    apb(1'b1, PC, 32'h100);
    apb(1'b1, LB, 32'h1);
    probeSel <= 1'b1;
    halfper(4);
    run <= 1'b0;
    repeat (4) @(posedge clk);
    check("rxClockOe", rxOe, 32'h1);
    check("rxClockOut", rxClk, linkIn.txClockPin);
    apb(1'b1, LB, 32'h0);
    apb(1'b1, RG, 32'h2000_0002);
    halfper(3);
    for (int i = 0; i < 16; i++) begin
      k = i[3:0];
      fsyncLevel <= k[1:0];
      apb(1'b1, PC, {28'h0, k[3:2], 2'b00});
      repeat (3) @(posedge clk);
      check("txFsyncActive", txAct, k[1] ^ k[3]);
      check("rxFsyncActive", rxAct, k[0] ^ k[2]);
    end
    run <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      sampleRise <= p[0];
      apb(1'b1, PC, {30'h0, p[0], p[0]});
      edge_seen(!p[0]);
      check("txLaunch", seen, 32'h1);
      edge_seen(p[0]);
      check("txLaunch", seen, 32'h0);
      wait (linkIn.rxClockPin !== p[0]);
      wait (linkIn.rxClockPin === p[0]);
      wv[0] = rxData;
      // look after the opposite edge has moved the data, so a wrong-edge sample shows
      repeat (6) @(posedge clk);
      check("rxSampled", rxSampled, wv[0]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
